// >>> core/gauge_regs_pkg.sv
/*
  Register map, field positions, reset values and timing counts shared by the
  gauge status and capacity register bank and its pin level filter helper.
  Assumes a single 25 MHz clock domain and a byte-wide register port.
*/
package gauge_regs_pkg;

  // Register addresses on the host link.
  localparam logic [7:0] ADDR_TEMPERATURE_AND_GAUGE = 8'h02;
  localparam logic [7:0] ADDR_CAPACITY_HIGH_BYTE    = 8'h03;
  localparam logic [7:0] ADDR_BATTERY_TYPE_BYTE     = 8'h04;
  localparam logic [7:0] ADDR_LEARNED_FULL_CAPACITY = 8'h05;
  localparam logic [7:0] ADDR_SECONDARY_FLAGS       = 8'h06;
  localparam logic [7:0] ADDR_PIN_PULLDOWN_DETECT   = 8'h07;
  localparam logic [7:0] ADDR_PIN_PULLUP_DETECT     = 8'h08;
  localparam logic [7:0] ADDR_CHARGES_WITHOUT_UPDATE = 8'h09;
  localparam logic [7:0] ADDR_CAPACITY_LOW_BYTE     = 8'h17;

  // Secondary flag byte bit positions; bits 7 and 1 are reserved and read zero.
  localparam int REGIME_LSB        = 4;
  localparam int SENSE_TEST_BIT    = 3;
  localparam int VALID_CHARGE_BIT  = 2;
  localparam int OVERLOAD_BIT      = 0;

  // Discharge regime encodings.
  localparam logic [2:0] REGIME_BELOW_HALF_C = 3'h0;
  localparam logic [2:0] REGIME_HALF_TO_2C   = 3'h1;
  localparam logic [2:0] REGIME_ABOVE_2C     = 3'h2;

  // Temperature bands: code 4 is the first band at or above 0 degrees C,
  // code 8 the first at or above 40 degrees C, code 12 the top band.
  localparam logic [3:0] BAND_ZERO_DEGREES  = 4'h4;
  localparam logic [3:0] BAND_FORTY_DEGREES = 4'h8;
  localparam logic [3:0] BAND_TOP           = 4'hC;

  // Compensation classes chosen from the temperature band.
  localparam logic [1:0] COMP_COLD   = 2'h0;
  localparam logic [1:0] COMP_NORMAL = 2'h1;
  localparam logic [1:0] COMP_HOT    = 2'h2;

  // Reset values.
  localparam logic [15:0] NOMINAL_CAPACITY_RESET = 16'h0000;
  localparam logic [7:0]  CHARGES_RESET          = 8'h00;
  localparam logic        INACCURATE_RESET       = 1'b1;

  // Charge counter limits.
  localparam logic [7:0] CHARGES_SATURATE   = 8'hFF;
  localparam logic [7:0] CHARGES_INACCURATE = 8'h40;

  // The 0.94 factor as a fraction of 256 (241/256 = 0.9414).
  localparam int unsigned NEAR_FULL_NUMERATOR = 241;

  // Overload hold after the rate falls below 2C.
  localparam longint unsigned CLOCK_HZ         = 25_000_000;
  localparam longint unsigned OVERLOAD_HOLD_MS = 500;
  localparam int unsigned OVERLOAD_HOLD_CYCLES =
    int'((CLOCK_HZ * OVERLOAD_HOLD_MS) / 1000);

  localparam int SEGMENT_COUNT = 5;

endpackage

// >>> core/pin_level_filter.sv
/*
  Three-stage synchroniser for the segment program-pin detection levels.
  A bit changes only when the second and third stages agree.
  Assumes raw levels arrive asynchronously from pad sensing logic.
*/
`timescale 1ns/1ns
module pin_level_filter
  import gauge_regs_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire logic [SEGMENT_COUNT-1:0] rawLevel,
  output logic      [SEGMENT_COUNT-1:0] filteredLevel
);

  logic [SEGMENT_COUNT-1:0] stageOne;
  logic [SEGMENT_COUNT-1:0] stageTwo;
  logic [SEGMENT_COUNT-1:0] stageThree;
  wire  [SEGMENT_COUNT-1:0] agreeMask = ~(stageTwo ^ stageThree);
  wire  [SEGMENT_COUNT-1:0] next_filteredLevel =
    (stageThree & agreeMask) | (filteredLevel & ~agreeMask);

  always_ff @(posedge clock) begin
    if (reset) begin
      stageOne      <= '0;
      stageTwo      <= '0;
      stageThree    <= '0;
      filteredLevel <= '0;
    end else begin
      stageOne      <= rawLevel;
      stageTwo      <= stageOne;
      stageThree    <= stageTwo;
      filteredLevel <= next_filteredLevel;
    end
  end

endmodule // pin_level_filter

// >>> core/gauge_sixteenths.sv
/*
  Remaining-capacity gauge in sixteenths of the learned full capacity.
  Assumes both inputs are stable registers of the same clock domain.
*/
`timescale 1ns/1ns
module gauge_sixteenths (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [7:0] compensatedCapacity,
  input  wire logic [7:0] learnedFullCapacity,
  output logic      [3:0] gaugeCode
);

  // Restoring division; the remainder stays below the divisor so nine bits do.
  function automatic logic [3:0] sixteenths(input logic [7:0] part, input logic [7:0] whole);
    logic [8:0] remainder;
    logic [3:0] quotient;
    remainder = {1'b0, part};
    quotient  = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      remainder = {remainder[7:0], 1'b0};
      if (remainder >= {1'b0, whole}) begin
        remainder   = remainder - {1'b0, whole};
        quotient[i] = 1'b1;
      end
    end
    return quotient;
  endfunction

  // A full or empty reference saturates rather than dividing by zero.
  wire       isEmptyReference = (learnedFullCapacity == 8'h00);
  wire       isAtLeastFull    = (compensatedCapacity >= learnedFullCapacity);
  wire [3:0] next_gaugeCode   = isEmptyReference ? 4'h0 :
                                isAtLeastFull    ? 4'hF :
                                sixteenths(compensatedCapacity, learnedFullCapacity);

  always_ff @(posedge clock) begin
    if (reset) begin
      gaugeCode <= 4'h0;
    end else begin
      gaugeCode <= next_gaugeCode;
    end
  end

endmodule // gauge_sixteenths

// >>> core/gauge_status_capacity_regs.sv
/*
  Status and capacity register bank of the battery gas gauge: temperature and
  gauge byte, nominal capacity, learned full capacity, battery type byte,
  secondary flags, program-pin detection and the charge-without-update count.
  Assumes the serial link logic presents a byte-wide register port with
  one-cycle read and write strobes, and that measurement logic on the same
  clock delivers one-cycle events and steady rate and temperature levels.
*/
`timescale 1ns/1ns
module gauge_status_capacity_regs
  import gauge_regs_pkg::*;
#(
  parameter int unsigned OverloadHoldCycles = OVERLOAD_HOLD_CYCLES
) (
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire logic [7:0]               regAddress,
  input  wire logic [7:0]               regWriteData,
  input  wire logic                     regWrite,
  input  wire logic                     regRead,
  output logic      [7:0]               regReadData,
  output logic                          regReadValid,
  input  wire logic                     validChargeEvent,
  input  wire logic                     chargeStepEvent,
  input  wire logic                     dischargeStepEvent,
  input  wire logic                     selfDischargeStepEvent,
  input  wire logic                     emptyDetectEvent,
  input  wire logic                     deviceResetEvent,
  input  wire logic [3:0]               temperatureBand,
  input  wire logic                     rateAboveHalfC,
  input  wire logic                     rateAboveTwoC,
  input  wire logic                     senseActivity,
  input  wire logic [7:0]               compensatedCapacity,
  input  wire logic [7:0]               dischargeCount,
  input  wire logic [7:0]               programmedFullCount,
  input  wire logic [SEGMENT_COUNT-1:0] segmentPullDown,
  input  wire logic [SEGMENT_COUNT-1:0] segmentPullUp,
  output logic                          capacityInaccurateFlag,
  output logic                          validDischargeQualifier,
  output logic                          firstEmptyWarning,
  output logic                          overloadFlag,
  output logic [1:0]                    compensationClass
);

  // Scale a byte by the 0.94 factor, rounding down.
  function automatic logic [7:0] nearFullOf(input logic [7:0] value);
    logic [15:0] product;
    product = 16'(value) * 16'(NEAR_FULL_NUMERATOR);
    return product[15:8];
  endfunction

  // Six percent of the learned capacity in nominal-capacity units (x 15.25).
  function automatic logic [15:0] sixPercentOf(input logic [7:0] value);
    return ({4'h0, value, 4'h0} - {8'h00, value}) + {10'h000, value[7:2]};
  endfunction

  function automatic logic [1:0] classOf(input logic [3:0] band);
    if (band < BAND_ZERO_DEGREES) begin
      return COMP_COLD;
    end
    if (band >= BAND_FORTY_DEGREES) begin
      return COMP_HOT;
    end
    return COMP_NORMAL;
  endfunction

  logic [15:0]              nominalCapacity;
  logic [7:0]               batteryTypeByte;
  logic [7:0]               learnedFullCapacity;
  logic [7:0]               chargesWithoutUpdate;
  logic                     validChargeFlag;
  logic                     reachedFull;
  logic                     chargeCountHeld;
  logic [15:0]              selfDischargeSince;
  logic [31:0]              overloadHold;
  logic [2:0]               dischargeRegimeCode;
  logic                     senseActivityTestBit;
  logic [3:0]               temperatureBandCode;
  logic [3:0]               gaugeSixteenthsCode;
  logic [SEGMENT_COUNT-1:0] pinPulldownDetect;
  logic [SEGMENT_COUNT-1:0] pinPullupDetect;

  // Software reset through the event input behaves like the reset pin for
  // gauge state; the battery type byte survives both, as backed-up storage.
  wire restore = reset | deviceResetEvent;

  // Host write decode.
  wire writeHigh    = regWrite && (regAddress == ADDR_CAPACITY_HIGH_BYTE);
  wire writeLow     = regWrite && (regAddress == ADDR_CAPACITY_LOW_BYTE);
  wire writeType    = regWrite && (regAddress == ADDR_BATTERY_TYPE_BYTE);
  wire writeLearned = regWrite && (regAddress == ADDR_LEARNED_FULL_CAPACITY);
  wire writeCharges = regWrite && (regAddress == ADDR_CHARGES_WITHOUT_UPDATE);

  // Capacity comparisons against the learned full reference.
  wire [7:0] nearFullLevel = nearFullOf(learnedFullCapacity);
  wire       isNearFull    = nominalCapacity[15:8] >= nearFullLevel;
  wire       isAtFull      = nominalCapacity[15:8] == learnedFullCapacity;

  // Learning event and the value it loads.
  wire       learnedUpdate = validChargeEvent && firstEmptyWarning &&
                             validDischargeQualifier;

  wire [7:0] learnedValue  = (dischargeCount < nearFullLevel) ? nearFullLevel
                                                              : dischargeCount;

  wire [7:0] next_learnedFullCapacity =
    learnedUpdate ? learnedValue :
    writeLearned  ? regWriteData :
                    learnedFullCapacity;

  // Nominal capacity counts saturate at both ends instead of wrapping.
  wire        countUp    = chargeStepEvent && (nominalCapacity != 16'hFFFF);
  wire        countDown  = (dischargeStepEvent || selfDischargeStepEvent) &&
                           (nominalCapacity != 16'h0000);
  wire [15:0] countedCapacity =
    (countUp && !countDown) ? nominalCapacity + 16'h0001 :
    (countDown && !countUp) ? nominalCapacity - 16'h0001 :
                              nominalCapacity;

  wire [15:0] next_nominalCapacity =
    writeHigh ? {regWriteData, nominalCapacity[7:0]} :
    writeLow  ? {nominalCapacity[15:8], regWriteData} :
                countedCapacity;

  // Near full, only the first valid charge counts until capacity falls away.
  wire chargeCounts = validChargeEvent && !(isNearFull && chargeCountHeld);
  wire countBelowTop = chargesWithoutUpdate != CHARGES_SATURATE;
  wire [7:0] next_chargesWithoutUpdate =
    learnedUpdate                  ? CHARGES_RESET :
    writeCharges                   ? regWriteData :
    (chargeCounts && countBelowTop) ? chargesWithoutUpdate + 8'h01 :
                                     chargesWithoutUpdate;

  wire reachesInaccurate = chargeCounts && countBelowTop &&
                           (chargesWithoutUpdate == CHARGES_INACCURATE - 8'h01);

  // The hold mark drops once capacity falls below the near-full level.
  wire next_chargeCountHeld = (validChargeEvent && isNearFull) ||
                              (chargeCountHeld && isNearFull);

  // Capacity-inaccurate flag. A learning charge also resets the counter, so
  // the clear must win over a count into 64 made by that same charge.
  wire next_capacityInaccurateFlag =
    learnedUpdate     ? 1'b0 :
    reachesInaccurate ? 1'b1 :
                        capacityInaccurateFlag;

  // Valid discharge qualifier: armed by the first discharge near full, lost on
  // charge, on excess self-discharge or on an empty warning below 0 C.
  wire qualifierStart = dischargeStepEvent && isNearFull && !validDischargeQualifier;
  wire tooMuchSelfDischarge = selfDischargeSince > sixPercentOf(learnedFullCapacity);
  wire coldEmpty = emptyDetectEvent && (temperatureBandCode < BAND_ZERO_DEGREES);
  wire qualifierStop = validChargeEvent || tooMuchSelfDischarge || coldEmpty;

  wire next_validDischargeQualifier =
    qualifierStart ? 1'b1 :
    qualifierStop  ? 1'b0 :
                     validDischargeQualifier;

  // The tally saturates so a long idle spell cannot wrap it back to zero.
  wire [15:0] next_selfDischargeSince =
    !next_validDischargeQualifier ? 16'h0000 :
    (selfDischargeStepEvent && selfDischargeSince != 16'hFFFF)
      ? selfDischargeSince + 16'h0001 : selfDischargeSince;

  // End-of-discharge sampling is suspended while the overload flag stands.
  wire next_firstEmptyWarning =
    (emptyDetectEvent && !overloadFlag) ? 1'b1 :
    validChargeEvent                    ? 1'b0 :
                                          firstEmptyWarning;

  // Valid charge flag and the full mark that arms its clear.
  // A discharge in the cycle that capacity reaches full is already the first.
  wire firstDischargeAfterFull = dischargeStepEvent && (reachedFull || isAtFull);
  wire next_validChargeFlag =
    validChargeEvent        ? 1'b1 :
    firstDischargeAfterFull ? 1'b0 :
                              validChargeFlag;
  wire next_reachedFull =
    isAtFull                          ? !dischargeStepEvent :
    (dischargeStepEvent && reachedFull) ? 1'b0 :
                                        reachedFull;

  // Overload hold timer counts down from the hold figure once below 2C.
  // A hold figure of zero would never release the flag.
  wire [31:0] holdCycles  = 32'(OverloadHoldCycles);
  wire [31:0] next_overloadHold =
    rateAboveTwoC           ? holdCycles :
    (overloadHold != 32'h0) ? overloadHold - 32'h0000_0001 :
                              overloadHold;

  wire next_overloadFlag =
    rateAboveTwoC ? 1'b1 :
    (overloadHold == 32'h0000_0001) ? 1'b0 :
                                      overloadFlag;

  wire [2:0] next_dischargeRegimeCode =
    rateAboveTwoC  ? REGIME_ABOVE_2C :
    rateAboveHalfC ? REGIME_HALF_TO_2C :
                     REGIME_BELOW_HALF_C;

  // Bands above the top code are reported as the top band.
  wire [3:0] next_temperatureBandCode =
    (temperatureBand > BAND_TOP) ? BAND_TOP : temperatureBand;
  wire [1:0] next_compensationClass = classOf(temperatureBand);

  // Read decode; reserved bits and unmapped addresses read as zero.
  wire [7:0] secondaryFlagsByte =
    (8'(dischargeRegimeCode) << REGIME_LSB) |
    (8'(senseActivityTestBit) << SENSE_TEST_BIT) |
    (8'(validChargeFlag) << VALID_CHARGE_BIT) |
    (8'(overloadFlag) << OVERLOAD_BIT);

  logic [7:0] readSelect;
  always_comb begin
    unique case (regAddress)
      ADDR_TEMPERATURE_AND_GAUGE:  readSelect = {temperatureBandCode,
                                                 gaugeSixteenthsCode};
      ADDR_CAPACITY_HIGH_BYTE:     readSelect = nominalCapacity[15:8];
      ADDR_CAPACITY_LOW_BYTE:      readSelect = nominalCapacity[7:0];
      ADDR_BATTERY_TYPE_BYTE:      readSelect = batteryTypeByte;
      ADDR_LEARNED_FULL_CAPACITY:  readSelect = learnedFullCapacity;
      ADDR_SECONDARY_FLAGS:        readSelect = secondaryFlagsByte;
      ADDR_PIN_PULLDOWN_DETECT:    readSelect = 8'(pinPulldownDetect);
      ADDR_PIN_PULLUP_DETECT:      readSelect = 8'(pinPullupDetect);
      ADDR_CHARGES_WITHOUT_UPDATE: readSelect = chargesWithoutUpdate;
      default:                     readSelect = 8'h00;
    endcase
  end

  // Gauge state restored by either reset source; learned capacity reloads from programmedFullCount.
  always_ff @(posedge clock) begin
    if (restore) begin
      nominalCapacity         <= NOMINAL_CAPACITY_RESET;
      learnedFullCapacity     <= programmedFullCount;
      chargesWithoutUpdate    <= CHARGES_RESET;
      capacityInaccurateFlag  <= INACCURATE_RESET;
      validDischargeQualifier <= 1'b0;
      selfDischargeSince      <= 16'h0000;
      chargeCountHeld         <= 1'b0;
    end else begin
      nominalCapacity         <= next_nominalCapacity;
      learnedFullCapacity     <= next_learnedFullCapacity;
      chargesWithoutUpdate    <= next_chargesWithoutUpdate;
      capacityInaccurateFlag  <= next_capacityInaccurateFlag;
      validDischargeQualifier <= next_validDischargeQualifier;
      selfDischargeSince      <= next_selfDischargeSince;
      chargeCountHeld         <= next_chargeCountHeld;
    end
  end

  // Flags and measurement snapshots follow the reset pin only.
  always_ff @(posedge clock) begin
    if (reset) begin
      firstEmptyWarning    <= 1'b0;
      validChargeFlag      <= 1'b0;
      reachedFull          <= 1'b0;
      overloadFlag         <= 1'b0;
      overloadHold         <= 32'h0000_0000;
      dischargeRegimeCode  <= REGIME_BELOW_HALF_C;
      senseActivityTestBit <= 1'b0;
      temperatureBandCode  <= 4'h0;
      compensationClass    <= COMP_COLD;
    end else begin
      firstEmptyWarning    <= next_firstEmptyWarning;
      validChargeFlag      <= next_validChargeFlag;
      reachedFull          <= next_reachedFull;
      overloadFlag         <= next_overloadFlag;
      overloadHold         <= next_overloadHold;
      dischargeRegimeCode  <= next_dischargeRegimeCode;
      senseActivityTestBit <= senseActivity;
      temperatureBandCode  <= next_temperatureBandCode;
      compensationClass    <= next_compensationClass;
    end
  end

  // Battery type byte has no reset value: it models storage held by backup supply.
  always_ff @(posedge clock) begin
    if (writeType) begin
      batteryTypeByte <= regWriteData;
    end
  end

  // Read data holds until the next read, so a slow host may sample it late.
  always_ff @(posedge clock) begin
    if (reset) begin
      regReadData  <= 8'h00;
      regReadValid <= 1'b0;
    end else begin
      regReadData  <= regRead ? readSelect : regReadData;
      regReadValid <= regRead;
    end
  end

  gauge_sixteenths gaugeUnit (
    .clock               (clock),
    .reset               (reset),
    .compensatedCapacity (compensatedCapacity),
    .learnedFullCapacity (learnedFullCapacity),
    .gaugeCode           (gaugeSixteenthsCode)
  );

  pin_level_filter pulldownFilter (
    .clock         (clock),
    .reset         (reset),
    .rawLevel      (segmentPullDown),
    .filteredLevel (pinPulldownDetect)
  );

  pin_level_filter pullupFilter (
    .clock         (clock),
    .reset         (reset),
    .rawLevel      (segmentPullUp),
    .filteredLevel (pinPullupDetect)
  );

endmodule // gauge_status_capacity_regs

// >>> testbench/gauge_regs_checker.sv
/* Port checker for the gauge register bank.
   Assumes it is bound to every gauge_status_capacity_regs instance. */
`timescale 1ns/1ns
module gauge_regs_checker
  import gauge_regs_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       regRead,
  input wire logic       regReadValid,
  input wire logic       rateAboveTwoC,
  input wire logic [3:0] temperatureBand,
  input wire logic       validChargeEvent,
  input wire logic       emptyDetectEvent,
  input wire logic       deviceResetEvent,
  input wire logic       capacityInaccurateFlag,
  input wire logic       validDischargeQualifier,
  input wire logic       firstEmptyWarning,
  input wire logic       overloadFlag,
  input wire logic [1:0] compensationClass
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  read_answer_a: assert property (regRead |=> regReadValid)
    else $error("read strobe got no answer");
  reset_state_a: assert property (disable iff (1'b0)
    reset |=> capacityInaccurateFlag && !overloadFlag)
    else $error("reset state of flags wrong");
  overload_set_a: assert property (rateAboveTwoC |=> overloadFlag)
    else $error("overload not raised");
  // The hold check stops at 8 cycles so the shortened hold still covers it.
  overload_hold_a: assert property ($fell(rateAboveTwoC) && overloadFlag
    |-> overloadFlag [*8])
    else $error("overload dropped early");
  overload_cause_a: assert property (!overloadFlag && !rateAboveTwoC
    |=> !overloadFlag)
    else $error("overload without cause");
  cold_class_a: assert property (temperatureBand < BAND_ZERO_DEGREES
    |=> compensationClass == COMP_COLD)
    else $error("cold band picked wrong class");
  empty_block_a: assert property (emptyDetectEvent && overloadFlag && !firstEmptyWarning
    |=> !firstEmptyWarning)
    else $error("empty sampled during overload");
  soft_reset_a: assert property (deviceResetEvent
    |=> capacityInaccurateFlag && !validDischargeQualifier)
    else $error("device reset left flags");
  cover property (overloadFlag ##1 !overloadFlag);
  cover property (validChargeEvent && firstEmptyWarning);
  cover property (deviceResetEvent);
endmodule // gauge_regs_checker

bind gauge_status_capacity_regs gauge_regs_checker gauge_regs_checker_i (
  .clock(clock), .reset(reset), .regRead(regRead), .regReadValid(regReadValid),
  .rateAboveTwoC(rateAboveTwoC), .temperatureBand(temperatureBand),
  .validChargeEvent(validChargeEvent), .emptyDetectEvent(emptyDetectEvent),
  .deviceResetEvent(deviceResetEvent), .capacityInaccurateFlag(capacityInaccurateFlag),
  .validDischargeQualifier(validDischargeQualifier),
  .firstEmptyWarning(firstEmptyWarning), .overloadFlag(overloadFlag),
  .compensationClass(compensationClass));

// >>> testbench/host_link_model.sv
/* Host side of the register port: byte reads and writes.
   Assumes one-cycle strobes and a read answer one cycle later. */
`timescale 1ns/1ns
module host_link_model
  import gauge_regs_pkg::*;
(
  input  wire logic       clock,
  output logic      [7:0] regAddress,
  output logic      [7:0] regWriteData,
  output logic            regWrite,
  output logic            regRead,
  input  wire logic [7:0] regReadData,
  input  wire logic       regReadValid
);
  initial begin
    regAddress = 8'hFF;
    regWriteData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // Released lines show inverted values so a stale address is never reused.
  task automatic write(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    regAddress = a;
    regWriteData = (a == ADDR_SECONDARY_FLAGS) ? (v & 8'h7D) : v;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
    regAddress = ~a;
    regWriteData = ~regWriteData;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] v, output logic ok);
    @(negedge clock);
    regAddress = a;
    regRead = 1'b1;
    @(negedge clock);
    regRead = 1'b0;
    regAddress = ~a;
    ok = regReadValid;
    v = (a == ADDR_SECONDARY_FLAGS) ? (regReadData & 8'hF7) : regReadData;
  endtask
endmodule // host_link_model

// >>> testbench/gauge_status_capacity_regs_bench.sv
/* Self-checking bench for the gauge register bank.
   Assumes a 20-cycle overload hold and events driven on falling edges. */
`timescale 1ns/1ns
module gauge_status_capacity_regs_bench;
  import gauge_regs_pkg::*;
  logic       clock, reset, wr, rd, rv, halfC, twoC, sense, ci, valid_discharge_qualifier, empty_warning, overload_flag;
  logic [7:0] addr, wdata, rdata, compensated_capacity, dcount, programmed_full_count, d;
  logic [5:0] ev;
  logic [3:0] band;
  logic [1:0] cls;
  logic [4:0] pd, pu;
  int         nErrors, numChecks, cycles;
  gauge_status_capacity_regs #(.OverloadHoldCycles(20)) gauge_status_capacity_regs_i (
    .clock(clock), .reset(reset), .regAddress(addr), .regWriteData(wdata),
    .regWrite(wr), .regRead(rd), .regReadData(rdata), .regReadValid(rv),
    .validChargeEvent(ev[0]), .chargeStepEvent(ev[1]), .dischargeStepEvent(ev[2]),
    .selfDischargeStepEvent(ev[3]), .emptyDetectEvent(ev[4]),
    .deviceResetEvent(ev[5]), .temperatureBand(band), .rateAboveHalfC(halfC),
    .rateAboveTwoC(twoC), .senseActivity(sense), .compensatedCapacity(compensated_capacity),
    .dischargeCount(dcount), .programmedFullCount(programmed_full_count), .segmentPullDown(pd),
    .segmentPullUp(pu), .capacityInaccurateFlag(ci), .validDischargeQualifier(valid_discharge_qualifier),
    .firstEmptyWarning(empty_warning), .overloadFlag(overload_flag), .compensationClass(cls));
  host_link_model host_link_model_i (.clock(clock), .regAddress(addr),
    .regWriteData(wdata), .regWrite(wr), .regRead(rd), .regReadData(rdata),
    .regReadValid(rv));
  task automatic summarize;
    $display("checks %0d mismatches %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rx(input logic [7:0] a, input logic [7:0] exp);
    logic ok;
    host_link_model_i.read(a, d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, exp);
  endtask
  task automatic wx(input logic [7:0] a, input logic [7:0] v);
    host_link_model_i.write(a, v);
  endtask
  task automatic pulse(input int k);
    @(negedge clock);
    ev[k] = 1'b1;
    @(negedge clock);
    ev[k] = 1'b0;
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      nErrors++;
      summarize();
    end
  end
  initial begin
    {reset, ev, band, halfC, twoC, sense} = {1'b1, 6'h00, 4'h2, 3'h1};
    {compensated_capacity, dcount, programmed_full_count, pd, pu} = {8'h40, 8'h60, 8'h80, 5'h09, 5'h14};
    {nErrors, numChecks, cycles} = '0;
    repeat (20) @(negedge clock);
    reset = 1'b0;
    band = 4'h5;
    rx(ADDR_CAPACITY_HIGH_BYTE, 8'h00);
    rx(ADDR_CAPACITY_LOW_BYTE, 8'h00);
    rx(ADDR_LEARNED_FULL_CAPACITY, 8'h80);
    rx(8'h0A, 8'h00);
    check({7'h00, ci}, 8'h01);
    rx(ADDR_PIN_PULLDOWN_DETECT, 8'h09);
    rx(ADDR_PIN_PULLUP_DETECT, 8'h14);
    wx(ADDR_BATTERY_TYPE_BYTE, 8'h5A);
    rx(ADDR_BATTERY_TYPE_BYTE, 8'h5A);
    wx(ADDR_TEMPERATURE_AND_GAUGE, 8'hFF);
    rx(ADDR_TEMPERATURE_AND_GAUGE, 8'h58);
    check({6'h00, cls}, {6'h00, COMP_NORMAL});
    band = 4'hF;
    rx(ADDR_TEMPERATURE_AND_GAUGE, 8'hC8);
    check({6'h00, cls}, {6'h00, COMP_HOT});
    band = 4'h2;
    @(negedge clock);
    check({6'h00, cls}, {6'h00, COMP_COLD});
    band = 4'h5;
    $display("map test done");
    wx(ADDR_CAPACITY_HIGH_BYTE, 8'h10);
    wx(ADDR_CAPACITY_LOW_BYTE, 8'hFF);
    pulse(1);
    rx(ADDR_CAPACITY_HIGH_BYTE, 8'h11);
    pulse(2);
    pulse(3);
    rx(ADDR_CAPACITY_LOW_BYTE, 8'hFE);
    rx(ADDR_CAPACITY_HIGH_BYTE, 8'h10);
    $display("count test done");
    halfC = 1'b1;
    rx(ADDR_SECONDARY_FLAGS, 8'h10);
    twoC = 1'b1;
    rx(ADDR_SECONDARY_FLAGS, 8'h21);
    pulse(4);
    check({7'h00, empty_warning}, 8'h00);
    {twoC, halfC} = 2'b00;
    repeat (8) @(negedge clock);
    check({7'h00, overload_flag}, 8'h01);
    repeat (16) @(negedge clock);
    check({7'h00, overload_flag}, 8'h00);
    pulse(0);
    rx(ADDR_SECONDARY_FLAGS, 8'h04);
    $display("flag test done");
    wx(ADDR_CAPACITY_HIGH_BYTE, 8'h80);
    pulse(2);
    check({7'h00, valid_discharge_qualifier}, 8'h01);
    rx(ADDR_SECONDARY_FLAGS, 8'h00);
    pulse(4);
    check({7'h00, empty_warning}, 8'h01);
    pulse(0);
    rx(ADDR_LEARNED_FULL_CAPACITY, 8'h78);
    rx(ADDR_CHARGES_WITHOUT_UPDATE, 8'h00);
    check({7'h00, ci}, 8'h00);
    $display("learning test done");
    wx(ADDR_CAPACITY_HIGH_BYTE, 8'h10);
    wx(ADDR_CHARGES_WITHOUT_UPDATE, 8'h3E);
    pulse(0);
    check({7'h00, ci}, 8'h00);
    pulse(0);
    rx(ADDR_CHARGES_WITHOUT_UPDATE, 8'h40);
    check({7'h00, ci}, 8'h01);
    wx(ADDR_CHARGES_WITHOUT_UPDATE, 8'hFE);
    pulse(0);
    pulse(0);
    rx(ADDR_CHARGES_WITHOUT_UPDATE, 8'hFF);
    wx(ADDR_CAPACITY_HIGH_BYTE, 8'h78);
    wx(ADDR_CHARGES_WITHOUT_UPDATE, 8'h05);
    pulse(0);
    pulse(0);
    rx(ADDR_CHARGES_WITHOUT_UPDATE, 8'h06);
    pulse(2);
    rx(ADDR_SECONDARY_FLAGS, 8'h00);
    $display("charge count test done");
    pulse(5);
    rx(ADDR_LEARNED_FULL_CAPACITY, 8'h80);
    rx(ADDR_CAPACITY_HIGH_BYTE, 8'h00);
    rx(ADDR_CHARGES_WITHOUT_UPDATE, 8'h00);
    check({7'h00, ci}, 8'h01);
    $display("device reset test done");
    summarize();
  end
endmodule // gauge_status_capacity_regs_bench
